/* File: hw/tc_pkg.sv */
// Shared constants, field layouts and types of the timer counter block
package tc_pkg;

   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] TC_OFS_TSC     = 8'h00;
   localparam logic [7:0] TC_OFS_CNT     = 8'h04;
   localparam logic [7:0] TC_OFS_MOD     = 8'h08;
   localparam logic [7:0] TC_OFS_CH_BASE = 8'h10;
   localparam logic [7:0] TC_CH_STRIDE   = 8'h10;
   localparam logic [7:0] TC_CH_SC       = 8'h00;
   localparam logic [7:0] TC_CH_VH       = 8'h04;
   localparam logic [7:0] TC_CH_VL       = 8'h08;

   // ==========================================================
   // Field positions
   localparam int TC_TSC_CLKS_LSB = 0;
   localparam int TC_TSC_CAS_BIT  = 2;
   localparam int TC_TSC_OVERFLOW_INTERRUPT_ENABLE_BIT = 3;
   localparam int TC_TSC_TOF_BIT  = 4;
   localparam int TC_TSC_PS_LSB   = 5;
   localparam int TC_CSC_ELS_LSB  = 2;
   localparam int TC_CSC_MSA_BIT  = 4;
   localparam int TC_CSC_MSB_BIT  = 5;

   // ==========================================================
   // Reset values and count limits
   localparam logic [7:0]  TC_TSC_RST  = 8'h00;
   localparam logic [15:0] TC_MOD_RST  = 16'h0000;
   localparam logic [15:0] TC_CNT_RST  = 16'h0000;
   localparam logic [15:0] TC_CHV_RST  = 16'h0000;
   localparam logic [5:0]  TC_CSC_RST  = 6'h00;
   localparam logic [15:0] TC_FREE_TOP = 16'hFFFF;
   localparam logic [15:0] TC_ZERO     = 16'h0000;

   // ==========================================================
   // Clock source codes
   localparam logic [1:0] TC_CLKS_NONE  = 2'h0;
   localparam logic [1:0] TC_CLKS_BUS   = 2'h1;
   localparam logic [1:0] TC_CLKS_FIXED = 2'h2;
   localparam logic [1:0] TC_CLKS_EXT   = 2'h3;

   // ==========================================================
   // Types
   typedef struct packed {
      logic [2:0] ps;
      logic       overflow_flag;
      logic       overflow_interrupt_enable;
      logic       cas;
      logic [1:0] clks;
   } tc_tsc_t;

   typedef struct packed {
      logic       msb;
      logic       msa;
      logic [1:0] els;
   } tc_chctl_t;

   typedef enum logic [1:0] {
      TC_MODE_CAPTURE,
      TC_MODE_COMPARE,
      TC_MODE_EDGE_ALIGNED_PWM,
      TC_MODE_CENTRE_ALIGNED_PWM
   } tc_mode_t;

endpackage

/* File: hw/tc_timer.sv */
// Timer counter with modulo, clock select and coherent channel value bytes
`timescale 1ns/1ns
`default_nettype none

module tc_timer
   import tc_pkg::*;
#(
   parameter int NCH = 2
)(
   input  wire logic                  sys_clk,
   input  wire logic                  rst_n,
   input  wire logic [7:0]            avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire logic [31:0]           avs_writedata,
   input  wire logic [3:0]            avs_byteenable,
   output logic      [31:0]           avs_readdata,
   output logic                       avs_waitrequest,
   input  wire logic                  debug_halt,
   input  wire logic                  fixed_tick,
   input  wire logic                  ext_count_in,
   input  wire logic [NCH-1:0]        capture_evt,
   output logic                       overflow_irq,
   output logic      [15:0]           main_count,
   output logic                       count_down,
   output logic      [NCH-1:0][15:0]  channel_value
);

   // ==========================================================
   // Helpers
   function automatic logic ch_hit(input logic [7:0] addr, input int n,
                                   input logic [7:0] ofs);
      logic [7:0] base;
      base = 8'(TC_OFS_CH_BASE + TC_CH_STRIDE * 8'(n));
      return addr == 8'(base + ofs);
   endfunction

   function automatic tc_mode_t mode_of(input tc_chctl_t c, input logic cas);
      tc_mode_t m;
      if (cas)
         m = TC_MODE_CENTRE_ALIGNED_PWM;
      else if (c.msb)
         m = TC_MODE_EDGE_ALIGNED_PWM;
      else if (c.msa)
         m = TC_MODE_COMPARE;
      else
         m = TC_MODE_CAPTURE;
      return m;
   endfunction

   // ==========================================================
   // State
   tc_tsc_t           tsc;
   logic [15:0]       modulo;
   tc_chctl_t         chctl   [NCH];
   logic [15:0]       rd_buf  [NCH];
   logic [15:0]       wr_buf  [NCH];
   logic              rd_lat  [NCH];
   logic              rd_hi   [NCH];
   logic              wr_hi   [NCH];
   logic              wr_lo   [NCH];
   logic              wr_pend [NCH];
   logic [6:0]        pcnt;
   logic              ext_s1;
   logic              ext_s2;
   logic              ext_s3;
   logic              ext_lvl;
   logic              ext_rise;
   logic              src_tick;
   logic              ctick;
   logic [6:0]        ps_mask;
   logic [15:0]       top;
   logic [15:0]       ptop;
   logic [15:0]       next_count;
   logic              next_down;
   logic              ovf;
   logic              pwm_load;
   logic              rd_acc;
   logic              wr_acc;
   logic [31:0]       rd_mux;
   tc_mode_t          mode    [NCH];

   assign rd_acc = avs_read & ~avs_waitrequest;
   assign wr_acc = avs_write & ~avs_waitrequest;

   always_comb begin
      for (int n = 0; n < NCH; n++) begin
         mode[n] = mode_of(chctl[n], tsc.cas);
      end
   end

   // ==========================================================
   // Bus slave: waitrequest drops for one cycle, the access lands there
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0000_0000;
      end else if ((avs_read | avs_write) & avs_waitrequest) begin
         avs_waitrequest <= 1'b0;
         avs_readdata    <= avs_read ? rd_mux : 32'h0000_0000;
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (avs_address)
         TC_OFS_TSC: rd_mux[7:0] = tsc;
         TC_OFS_CNT: rd_mux[15:0] = main_count;
         TC_OFS_MOD: rd_mux[15:0] = modulo;
         default: rd_mux = 32'h0000_0000;
      endcase
      for (int n = 0; n < NCH; n++) begin
         if (ch_hit(avs_address, n, TC_CH_SC))
            rd_mux[5:0] = {chctl[n], 2'b00};
         // Latched buffer is shown only outside debug halt
         if (ch_hit(avs_address, n, TC_CH_VH))
            rd_mux[7:0] = (rd_lat[n] && !debug_halt) ? rd_buf[n][15:8]
                                                     : channel_value[n][15:8];
         if (ch_hit(avs_address, n, TC_CH_VL))
            rd_mux[7:0] = (rd_lat[n] && !debug_halt) ? rd_buf[n][7:0]
                                                     : channel_value[n][7:0];
      end
   end

   // ==========================================================
   // Timer status/control and modulo
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         tsc    <= TC_TSC_RST;
         modulo <= TC_MOD_RST;
      end else begin
         if (wr_acc && avs_address == TC_OFS_TSC && avs_byteenable[0]) begin
            tsc.ps   <= avs_writedata[TC_TSC_PS_LSB +: 3];
            tsc.overflow_interrupt_enable <= avs_writedata[TC_TSC_OVERFLOW_INTERRUPT_ENABLE_BIT];
            tsc.cas  <= avs_writedata[TC_TSC_CAS_BIT];
            tsc.clks <= avs_writedata[TC_TSC_CLKS_LSB +: 2];
            if (avs_writedata[TC_TSC_TOF_BIT])
               tsc.overflow_flag <= 1'b0;
         end
         // Set wins over a clear in the same cycle
         if (ovf)
            tsc.overflow_flag <= 1'b1;
         if (wr_acc && avs_address == TC_OFS_MOD) begin
            if (avs_byteenable[0])
               modulo[7:0] <= avs_writedata[7:0];
            if (avs_byteenable[1])
               modulo[15:8] <= avs_writedata[15:8];
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         overflow_irq <= 1'b0;
      else
         overflow_irq <= tsc.overflow_flag & tsc.overflow_interrupt_enable;
   end

   // ==========================================================
   // External source synchroniser; a rising edge counts once stages 2 and 3 agree
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ext_s1  <= 1'b0;
         ext_s2  <= 1'b0;
         ext_s3  <= 1'b0;
         ext_lvl <= 1'b0;
      end else begin
         ext_s1 <= ext_count_in;
         ext_s2 <= ext_s1;
         ext_s3 <= ext_s2;
         if (ext_s2 == ext_s3)
            ext_lvl <= ext_s3;
      end
   end

   assign ext_rise = (ext_s2 == ext_s3) & ext_s3 & ~ext_lvl;

   // ==========================================================
   // Clock select and prescaler
   always_comb begin
      case (tsc.clks)
         TC_CLKS_NONE:  src_tick = 1'b0;
         TC_CLKS_BUS:   src_tick = 1'b1;
         TC_CLKS_FIXED: src_tick = fixed_tick;
         TC_CLKS_EXT:   src_tick = ext_rise;
         default:       src_tick = 1'b0;
      endcase
   end

   assign ps_mask = 7'((8'h01 << tsc.ps) - 8'h01);
   // Counter is frozen while the debugger holds the core
   assign ctick = src_tick & ~debug_halt & ((pcnt & ps_mask) == ps_mask);

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         pcnt <= 7'h00;
      else if (src_tick && !debug_halt)
         pcnt <= 7'(pcnt + 7'h01);
   end

   // ==========================================================
   // Main counter
   assign top  = (modulo == TC_ZERO) ? TC_FREE_TOP : modulo;
   assign ptop = tsc.cas ? modulo : top;

   always_comb begin
      next_count = main_count;
      next_down  = count_down;
      ovf        = 1'b0;
      if (ctick) begin
         if (tsc.cas) begin
            if (!count_down) begin
               if (main_count >= modulo) begin
                  next_down  = 1'b1;
                  next_count = 16'(main_count - 16'h0001);
                  ovf        = 1'b1;
               end else begin
                  next_count = 16'(main_count + 16'h0001);
               end
            end else if (main_count == TC_ZERO) begin
               next_down  = 1'b0;
               next_count = 16'(main_count + 16'h0001);
            end else begin
               next_count = 16'(main_count - 16'h0001);
            end
         end else begin
            next_down = 1'b0;
            if (main_count >= top) begin
               next_count = TC_ZERO;
               ovf        = (main_count == top);
            end else begin
               next_count = 16'(main_count + 16'h0001);
            end
         end
      end
   end

   // Step into the terminal count while counting up
   assign pwm_load = ctick & ~next_down & (main_count != ptop) & (next_count == ptop);

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         main_count <= TC_CNT_RST;
         count_down <= 1'b0;
      end else begin
         main_count <= next_count;
         count_down <= next_down;
      end
   end

   // ==========================================================
   // Channel control, value and coherency latches
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int n = 0; n < NCH; n++) begin
            chctl[n]         <= TC_CSC_RST[5:2];
            channel_value[n] <= TC_CHV_RST;
            rd_buf[n]        <= TC_CHV_RST;
            wr_buf[n]        <= TC_CHV_RST;
            rd_lat[n]        <= 1'b0;
            rd_hi[n]         <= 1'b0;
            wr_hi[n]         <= 1'b0;
            wr_lo[n]         <= 1'b0;
            wr_pend[n]       <= 1'b0;
         end
      end else begin
         for (int n = 0; n < NCH; n++) begin
            // Buffered word waits for its counter event
            if (wr_pend[n] && mode[n] != TC_MODE_CAPTURE) begin
               if (mode[n] == TC_MODE_COMPARE ? ctick : pwm_load) begin
                  channel_value[n] <= wr_buf[n];
                  wr_pend[n]       <= 1'b0;
               end
            end
            if (capture_evt[n] && mode[n] == TC_MODE_CAPTURE)
               channel_value[n] <= main_count;
            // Read latch, capture mode only, frozen in debug halt
            if (rd_acc && mode[n] == TC_MODE_CAPTURE && !debug_halt) begin
               if (ch_hit(avs_address, n, TC_CH_VH) || ch_hit(avs_address, n, TC_CH_VL)) begin
                  if (!rd_lat[n]) begin
                     rd_lat[n] <= 1'b1;
                     rd_buf[n] <= channel_value[n];
                     rd_hi[n]  <= ch_hit(avs_address, n, TC_CH_VH);
                  end else if (rd_hi[n] != ch_hit(avs_address, n, TC_CH_VH)) begin
                     rd_lat[n] <= 1'b0;
                  end
               end
            end
            // Byte writes; capture mode drops them
            if (wr_acc && avs_byteenable[0] && mode[n] != TC_MODE_CAPTURE) begin
               if (ch_hit(avs_address, n, TC_CH_VH)) begin
                  if (debug_halt) begin
                     channel_value[n][15:8] <= avs_writedata[7:0];
                  end else begin
                     wr_buf[n][15:8] <= avs_writedata[7:0];
                     if (wr_lo[n]) begin
                        wr_lo[n] <= 1'b0;
                        if (tsc.clks == TC_CLKS_NONE)
                           channel_value[n] <= {avs_writedata[7:0], wr_buf[n][7:0]};
                        else
                           wr_pend[n] <= 1'b1;
                     end else begin
                        wr_hi[n] <= 1'b1;
                     end
                  end
               end
               if (ch_hit(avs_address, n, TC_CH_VL)) begin
                  if (debug_halt) begin
                     channel_value[n][7:0] <= avs_writedata[7:0];
                  end else begin
                     wr_buf[n][7:0] <= avs_writedata[7:0];
                     if (wr_hi[n]) begin
                        wr_hi[n] <= 1'b0;
                        if (tsc.clks == TC_CLKS_NONE)
                           channel_value[n] <= {wr_buf[n][15:8], avs_writedata[7:0]};
                        else
                           wr_pend[n] <= 1'b1;
                     end else begin
                        wr_lo[n] <= 1'b1;
                     end
                  end
               end
            end
            // Control write restarts both sequences, even in debug halt
            if (wr_acc && avs_byteenable[0] && ch_hit(avs_address, n, TC_CH_SC)) begin
               chctl[n]   <= avs_writedata[5:2];
               rd_lat[n]  <= 1'b0;
               wr_hi[n]   <= 1'b0;
               wr_lo[n]   <= 1'b0;
               wr_pend[n] <= 1'b0;
            end
         end
      end
   end

   // ==========================================================
   // Checks on the last channel, channel 0 and the counter
   a_capture_drops_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (wr_acc && ch_hit(avs_address, NCH-1, TC_CH_VL) && mode[NCH-1] == TC_MODE_CAPTURE
       && !capture_evt[NCH-1]) |=> channel_value[NCH-1] == $past(channel_value[NCH-1]))
      else $error("value changed by write in capture mode");
   a_halt_freezes_latch: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (debug_halt && !(wr_acc && ch_hit(avs_address, NCH-1, TC_CH_SC)))
       |=> rd_lat[NCH-1] == $past(rd_lat[NCH-1]))
      else $error("read latch moved in debug halt");
   a_halt_live_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (rd_acc && ch_hit(avs_address, NCH-1, TC_CH_VL) && debug_halt && $past(debug_halt)
       && !$past(capture_evt[NCH-1]) && !$past(pwm_load))
       |-> avs_readdata[7:0] == channel_value[NCH-1][7:0])
      else $error("debug read did not show live value");
   a_ctl_resets_seq: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (wr_acc && avs_byteenable[0] && ch_hit(avs_address, 0, TC_CH_SC))
       |=> !rd_lat[0] && !wr_hi[0] && !wr_lo[0] && !wr_pend[0])
      else $error("control write left a latch set");
   a_irq_follows_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (tsc.overflow_flag && tsc.overflow_interrupt_enable) ##1 (tsc.overflow_flag && tsc.overflow_interrupt_enable) |-> overflow_irq)
      else $error("overflow request missing");
   a_up_wrap_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (ctick && !tsc.cas && main_count == top)
       |=> main_count == TC_ZERO && tsc.overflow_flag)
      else $error("wrap without overflow flag");
   a_centre_turn: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (ctick && tsc.cas && !count_down && main_count == modulo && modulo != TC_ZERO)
       |=> count_down && tsc.overflow_flag && main_count == 16'($past(modulo) - 16'h0001))
      else $error("centre turn wrong");
   a_off_holds_count: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (tsc.clks == TC_CLKS_NONE) |=> $stable(main_count))
      else $error("counter moved with no source");
endmodule

`default_nettype wire

/* File: tb/test_tc_timer.sv */
// Self-checking bench for the timer counter block
`timescale 1ns/1ns
`default_nettype none

module test_tc_timer
   import tc_pkg::*;
;
   // ==========================================================
   // Signals and design
   logic             sys_clk, rst_n, avs_read, avs_write, debug_halt, fixed_tick;
   logic             ext_count_in, avs_waitrequest, overflow_irq, count_down;
   logic [7:0]       avs_address;
   logic [31:0]      avs_writedata, avs_readdata, rd;
   logic [3:0]       avs_byteenable;
   logic [15:0]      main_count;
   logic [1:0]       capture_evt;
   logic [1:0][15:0] channel_value;
   int               mismatches, checked;

   tc_timer #(.NCH(2)) DUT (
      .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .debug_halt(debug_halt), .fixed_tick(fixed_tick),
      .ext_count_in(ext_count_in), .capture_evt(capture_evt), .overflow_irq(overflow_irq),
      .main_count(main_count), .count_down(count_down), .channel_value(channel_value));

   // ==========================================================
   // Shared tasks
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One Avalon access; one idle edge after release avoids re-driving in the same step
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] be);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      if (wr) avs_write <= 1'b1;
      else avs_read <= 1'b1;
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0 && n < 50) begin
         n++;
         @(posedge sys_clk);
      end
      rd = avs_readdata;
      if (n >= 50) begin
         chk("waitrequest", 32'h0, 32'h1);
         summarize();
      end
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic wr8(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, a, {24'h0, d}, 4'h1);
   endtask

   task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
      bus(1'b0, a, 32'h0, 4'h1);
      chk(nm, {24'h0, e}, {24'h0, rd[7:0]});
   endtask

   task automatic tick(input logic [15:0] e);
      fixed_tick <= 1'b1;
      @(posedge sys_clk);
      fixed_tick <= 1'b0;
      @(posedge sys_clk);
      chk("main_count", {16'h0, e}, {16'h0, main_count});
   endtask

   task automatic cap1;
      capture_evt <= 2'b10;
      @(posedge sys_clk);
      capture_evt <= 2'b00;
      @(posedge sys_clk);
   endtask

   task automatic cv(input logic [15:0] e, input int ch);
      chk("channel_value", {16'h0, e}, {16'h0, channel_value[ch]});
   endtask

   task automatic summarize;
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_reset;
      cv(TC_CHV_RST, 0);
      cv(TC_CHV_RST, 1);
      rdc("status_control", 8'h00, 8'h00);
      rdc("unmapped", 8'hFC, 8'h00);
      $display("reset values done");
   endtask

   // Compare mode with no source: load exactly when the second byte lands
   task automatic t_nosrc;
      wr8(8'h10, 8'h10);
      wr8(8'h14, 8'h12);
      cv(16'h0000, 0);
      wr8(8'h18, 8'h34);
      cv(16'h1234, 0);
      wr8(8'h14, 8'hAA);
      debug_halt <= 1'b1;
      wr8(8'h14, 8'h11);
      wr8(8'h18, 8'h22);
      cv(16'h1122, 0);
      debug_halt <= 1'b0;
      wr8(8'h18, 8'hBB);
      cv(16'hAABB, 0);
      $display("direct and halted writes done");
   endtask

   task automatic t_capture;
      wr8(8'h20, 8'h04);
      wr8(8'h24, 8'hFF);
      wr8(8'h28, 8'hFF);
      cv(16'h0000, 1);
      wr8(8'h00, 8'h02);
      for (int i = 1; i <= 258; i++) tick(i[15:0]);
      cap1();
      rdc("value_high", 8'h24, 8'h01);
      tick(16'h0103);
      cap1();
      rdc("value_low", 8'h28, 8'h02);
      rdc("value_high", 8'h24, 8'h01);
      wr8(8'h20, 8'h04);
      tick(16'h0104);
      cap1();
      rdc("value_low", 8'h28, 8'h04);
      rdc("value_high", 8'h24, 8'h01);
      rdc("value_high", 8'h24, 8'h01);
      tick(16'h0105);
      cap1();
      debug_halt <= 1'b1;
      rdc("value_low", 8'h28, 8'h05);
      rdc("value_high", 8'h24, 8'h01);
      debug_halt <= 1'b0;
      rdc("value_low", 8'h28, 8'h04);
      wr8(8'h00, 8'h00);
      tick(16'h0105);
      wr8(8'h00, 8'h02);
      $display("capture coherency done");
   endtask

   task automatic t_buffered;
      wr8(8'h14, 8'h56);
      wr8(8'h18, 8'h78);
      repeat (3) @(posedge sys_clk);
      cv(16'hAABB, 0);
      tick(16'h0106);
      cv(16'h5678, 0);
      bus(1'b1, 8'h08, 32'h0000_0108, 4'h3);
      wr8(8'h00, 8'h0A);
      wr8(8'h10, 8'h28);
      wr8(8'h14, 8'h9A);
      wr8(8'h18, 8'hBC);
      tick(16'h0107);
      cv(16'h5678, 0);
      tick(16'h0108);
      cv(16'h9ABC, 0);
      chk("overflow_irq", 32'h0, {31'h0, overflow_irq});
      tick(16'h0000);
      rdc("status_control", 8'h00, 8'h1A);
      chk("overflow_irq", 32'h1, {31'h0, overflow_irq});
      wr8(8'h00, 8'h1A);
      @(posedge sys_clk);
      chk("overflow_irq", 32'h0, {31'h0, overflow_irq});
      $display("buffered transfers done");
   endtask

   task automatic t_centre;
      bus(1'b1, 8'h08, 32'h0000_0003, 4'h3);
      wr8(8'h00, 8'h06);
      tick(16'h0001);
      tick(16'h0002);
      tick(16'h0003);
      rdc("status_control", 8'h00, 8'h06);
      tick(16'h0002);
      chk("count_down", 32'h1, {31'h0, count_down});
      rdc("status_control", 8'h00, 8'h16);
      tick(16'h0001);
      tick(16'h0000);
      tick(16'h0001);
      wr8(8'h20, 8'h10);
      wr8(8'h00, 8'h03);
      ext_count_in <= 1'b1;
      repeat (8) @(posedge sys_clk);
      ext_count_in <= 1'b0;
      repeat (8) @(posedge sys_clk);
      chk("main_count", 32'h2, {16'h0, main_count});
      // Prescale of two: two source ticks give one count whatever the phase
      wr8(8'h00, 8'h22);
      repeat (2) begin
         fixed_tick <= 1'b1;
         @(posedge sys_clk);
         fixed_tick <= 1'b0;
         @(posedge sys_clk);
      end
      chk("main_count", 32'h3, {16'h0, main_count});
      $display("centre and external source done");
   endtask

   // ==========================================================
   // Clock, watchdog and sequence
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   // Whole run needs about 700 cycles; the 20000-cycle limit, near thirty times that, means a hang
   initial begin
      repeat (20000) @(posedge sys_clk);
      mismatches++;
      summarize();
   end

   initial begin
      mismatches = 0;
      checked = 0;
      rst_n = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 8'h00;
      avs_writedata = 32'h0;
      avs_byteenable = 4'h0;
      debug_halt = 1'b0;
      fixed_tick = 1'b0;
      ext_count_in = 1'b0;
      capture_evt = 2'b00;
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      t_reset();
      t_nosrc();
      t_capture();
      t_buffered();
      t_centre();
      summarize();
   end
endmodule

`default_nettype wire
